// *** logic/splcm_pkg.sv ***
// package: register offsets, field positions and carriers for the serial port
package splcm_pkg;
  localparam logic [2:0] OFF_DATA = 3'h0;
  localparam logic [2:0] OFF_IER = 3'h1;
  localparam logic [2:0] OFF_IIR = 3'h2;
  localparam logic [2:0] OFF_LCR = 3'h3;
  localparam logic [2:0] OFF_MCR = 3'h4;
  localparam logic [2:0] OFF_LSR = 3'h5;
  localparam logic [2:0] OFF_MSR = 3'h6;
  localparam logic [2:0] OFF_SCR = 3'h7;
  localparam int B_DIVISOR_ACCESS_SEL = 7;
  localparam int B_BRK = 6;
  localparam int B_STICK = 5;
  localparam int B_EVEN = 4;
  localparam int B_PEN = 3;
  localparam int B_STB = 2;
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [7:0] IER_MASK = 8'h0f;
  localparam logic [7:0] MCR_MASK = 8'h1f;
  localparam logic [7:0] IIR_IDLE = 8'h01;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [3:0] OVS = 4'hf; // sixteen ticks per bit, minus one
  localparam logic [3:0] OVS_HALF = 4'h7;
  localparam logic [4:0] STOP_ONE = 5'h0f;
  localparam logic [4:0] STOP_ONEHALF = 5'h17;
  localparam logic [4:0] STOP_TWO = 5'h1f;
  localparam logic [2:0] LEN_BASE = 3'h4; // word length minus one for code 00
  typedef struct packed {
    logic divisor_access_sel;
    logic brk;
    logic stick;
    logic even;
    logic parity_on;
    logic stb;
    logic [1:0] wls;
  } splcm_lcr_t;
  typedef struct packed {
    logic err;
    logic temt;
    logic thre;
    logic bi;
    logic fe;
    logic pe;
    logic oe;
    logic dr;
  } splcm_lsr_t;
endpackage : splcm_pkg

// *** logic/splcm_uart.sv ***
// serial port: register map, character format control, transmitter, receiver
// Function
// - format register at offset 3, read/write
// - access bit clear selects data and enables
// - access bit set selects divisor bytes
// - break clear: output follows transmitter
// - break set: output held low
// - normal parity follows even select
// - stick parity sends inverse of even select
// - parity between data and stop; odd/even
// - length field gives 5 to 8 bits
// - stop control gives 1, 1.5 or 2
// - divisor write reloads counter, idles receiver; a transmit frame in progress runs on
`timescale 1ns/1ns
`default_nettype none
module splcm_uart (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic SIN,
  output logic SERIAL_OUT_PIN
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  splcm_pkg::splcm_lcr_t lcr_reg;
  logic [7:0] ier_reg, mcr_reg, scr_reg, rbr_reg, thr_reg, rdata_reg;
  logic [15:0] div_reg, baud_cnt_reg;
  logic thr_full_reg, dr_reg, oe_reg, pe_reg, fe_reg, bi_reg;
  logic [2:0] sin_sync_reg;
  logic sin_filt_reg;
  // address decode
  wire divisor_access_sel = lcr_reg.divisor_access_sel;
  wire sel_data = (ADDR == splcm_pkg::OFF_DATA) && !divisor_access_sel;
  wire sel_ier = (ADDR == splcm_pkg::OFF_IER) && !divisor_access_sel;
  wire sel_dll = (ADDR == splcm_pkg::OFF_DATA) && divisor_access_sel;
  wire sel_dlm = (ADDR == splcm_pkg::OFF_IER) && divisor_access_sel;
  wire div_wr = WR && (sel_dll || sel_dlm);
  wire thr_wr = WR && sel_data;
  wire rbr_rd = RD && sel_data;
  wire lsr_rd = RD && (ADDR == splcm_pkg::OFF_LSR);
  // baud tick: sixteen per bit
  wire tick = (baud_cnt_reg <= 16'h0001);
  // character format
  wire [2:0] len_m1 = splcm_pkg::LEN_BASE + {1'b0, lcr_reg.wls};
  wire par_odd = ~lcr_reg.even; // level giving an odd count of ones
  wire [4:0] stop_len = !lcr_reg.stb ? splcm_pkg::STOP_ONE :
    (lcr_reg.wls == 2'b00) ? splcm_pkg::STOP_ONEHALF :
    splcm_pkg::STOP_TWO;
  ////////////////////////////////////////////////////////////////////////////
  // transmitter
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
    splcm_tx_t;
  splcm_tx_t tx_st_reg;
  logic [7:0] tx_sh_reg;
  logic [2:0] tx_bit_reg;
  logic [4:0] tx_cnt_reg;
  logic tx_par_reg, tx_line_reg;
  wire tx_busy = (tx_st_reg != TX_IDLE);
  // stick parity sends a fixed level, opposite to the even select
  wire tx_par_bit = lcr_reg.stick ? par_odd :
    (tx_par_reg ^ tx_sh_reg[0] ^ par_odd);
  // serial output: break forces spacing
  assign SERIAL_OUT_PIN = lcr_reg.brk ? 1'b0 : tx_line_reg;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      tx_st_reg <= TX_IDLE;
      tx_sh_reg <= 8'h00;
      tx_bit_reg <= 3'h0;
      tx_cnt_reg <= 5'h00;
      tx_par_reg <= 1'b0;
      tx_line_reg <= 1'b1;
    end else begin
      case (tx_st_reg)
        TX_IDLE: begin
          tx_line_reg <= 1'b1;
          if (thr_full_reg && !div_wr) begin
            tx_st_reg <= TX_START;
            tx_sh_reg <= thr_reg;
            tx_par_reg <= 1'b0;
            tx_bit_reg <= 3'h0;
            tx_cnt_reg <= 5'h00;
            tx_line_reg <= 1'b0;
          end
        end
        TX_START: if (tick) begin
          tx_cnt_reg <= tx_cnt_reg + 5'h01;
          if (tx_cnt_reg[3:0] == splcm_pkg::OVS) begin
            tx_st_reg <= TX_DATA;
            tx_cnt_reg <= 5'h00;
            tx_line_reg <= tx_sh_reg[0];
          end
        end
        TX_DATA: if (tick) begin
          tx_cnt_reg <= tx_cnt_reg + 5'h01;
          if (tx_cnt_reg[3:0] == splcm_pkg::OVS) begin
            tx_cnt_reg <= 5'h00;
            tx_par_reg <= tx_par_reg ^ tx_sh_reg[0];
            tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
            tx_bit_reg <= tx_bit_reg + 3'h1;
            if (tx_bit_reg == len_m1) begin
              tx_st_reg <= lcr_reg.parity_on ? TX_PAR : TX_STOP;
              tx_line_reg <= lcr_reg.parity_on ? tx_par_bit : 1'b1;
            end else begin
              tx_line_reg <= tx_sh_reg[1];
            end
          end
        end
        TX_PAR: if (tick) begin
          tx_cnt_reg <= tx_cnt_reg + 5'h01;
          if (tx_cnt_reg[3:0] == splcm_pkg::OVS) begin
            tx_st_reg <= TX_STOP;
            tx_cnt_reg <= 5'h00;
            tx_line_reg <= 1'b1;
          end
        end
        TX_STOP: if (tick) begin
          tx_cnt_reg <= tx_cnt_reg + 5'h01;
          if (tx_cnt_reg == stop_len) begin
            tx_st_reg <= TX_IDLE;
          end
        end
        default: tx_st_reg <= TX_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // receiver
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
    splcm_rx_t;
  splcm_rx_t rx_st_reg;
  logic [7:0] rx_sh_reg;
  logic [2:0] rx_bit_reg;
  logic [3:0] rx_cnt_reg;
  logic rx_par_reg, rx_perr_reg;
  wire rx_line = sin_filt_reg;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sin_sync_reg <= 3'b111;
      sin_filt_reg <= 1'b1;
    end else begin
      sin_sync_reg <= {sin_sync_reg[1:0], SIN};
      if (sin_sync_reg[1] == sin_sync_reg[2]) begin
        sin_filt_reg <= sin_sync_reg[2];
      end
    end
  end
  // bit-centred sampling; divisor write drops any frame in progress
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rx_st_reg <= RX_IDLE;
      rx_sh_reg <= 8'h00;
      rx_bit_reg <= 3'h0;
      rx_cnt_reg <= 4'h0;
      rx_par_reg <= 1'b0;
      rx_perr_reg <= 1'b0;
    end else if (div_wr) begin
      rx_st_reg <= RX_IDLE;
    end else begin
      case (rx_st_reg)
        RX_IDLE: if (!rx_line) begin
          rx_st_reg <= RX_START;
          rx_cnt_reg <= 4'h0;
        end
        RX_START: if (tick) begin
          rx_cnt_reg <= rx_cnt_reg + 4'h1;
          if (rx_cnt_reg == splcm_pkg::OVS_HALF) begin
            rx_cnt_reg <= 4'h0;
            rx_bit_reg <= 3'h0;
            rx_par_reg <= 1'b0;
            rx_sh_reg <= 8'h00;
            rx_st_reg <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: if (tick) begin
          rx_cnt_reg <= rx_cnt_reg + 4'h1;
          if (rx_cnt_reg == splcm_pkg::OVS) begin
            rx_sh_reg <= rx_sh_reg | ({7'h00, rx_line} << rx_bit_reg);
            rx_par_reg <= rx_par_reg ^ rx_line;
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == len_m1) begin
              rx_st_reg <= lcr_reg.parity_on ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: if (tick) begin
          rx_cnt_reg <= rx_cnt_reg + 4'h1;
          if (rx_cnt_reg == splcm_pkg::OVS) begin
            rx_perr_reg <= lcr_reg.stick ? (rx_line != par_odd) :
              ((rx_par_reg ^ rx_line) != par_odd);
            rx_st_reg <= RX_STOP;
          end
        end
        RX_STOP: if (tick) begin
          rx_cnt_reg <= rx_cnt_reg + 4'h1;
          if (rx_cnt_reg == splcm_pkg::OVS) begin
            rx_st_reg <= RX_IDLE;
          end
        end
        default: rx_st_reg <= RX_IDLE;
      endcase
    end
  end
  wire rx_done = !div_wr && (rx_st_reg == RX_STOP) && tick &&
    (rx_cnt_reg == splcm_pkg::OVS);
  ////////////////////////////////////////////////////////////////////////////
  // register file and baud counter
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      lcr_reg <= splcm_pkg::LCR_RST;
      ier_reg <= 8'h00;
      mcr_reg <= 8'h00;
      scr_reg <= 8'h00;
      thr_reg <= 8'h00;
      div_reg <= splcm_pkg::DIV_RST;
      baud_cnt_reg <= splcm_pkg::DIV_RST;
    end else begin
      if (WR && ADDR == splcm_pkg::OFF_LCR) lcr_reg <= WDATA;
      if (WR && sel_ier) ier_reg <= WDATA & splcm_pkg::IER_MASK;
      if (WR && ADDR == splcm_pkg::OFF_MCR) mcr_reg <= WDATA & splcm_pkg::MCR_MASK;
      if (WR && ADDR == splcm_pkg::OFF_SCR) scr_reg <= WDATA;
      if (thr_wr) thr_reg <= WDATA;
      if (WR && sel_dll) div_reg[7:0] <= WDATA;
      if (WR && sel_dlm) div_reg[15:8] <= WDATA;
      // reload at once on a divisor write
      if (WR && sel_dll) begin
        baud_cnt_reg <= {div_reg[15:8], WDATA};
      end else if (WR && sel_dlm) begin
        baud_cnt_reg <= {WDATA, div_reg[7:0]};
      end else if (tick) begin
        baud_cnt_reg <= div_reg;
      end else begin
        baud_cnt_reg <= baud_cnt_reg - 16'h0001;
      end
    end
  end
  // status flags: hardware set wins over read clear
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      thr_full_reg <= 1'b0;
      rbr_reg <= 8'h00;
      dr_reg <= 1'b0;
      oe_reg <= 1'b0;
      pe_reg <= 1'b0;
      fe_reg <= 1'b0;
      bi_reg <= 1'b0;
    end else begin
      if (thr_wr) thr_full_reg <= 1'b1;
      else if (!tx_busy && !div_wr) thr_full_reg <= 1'b0;
      if (rx_done) begin
        rbr_reg <= rx_sh_reg;
        dr_reg <= 1'b1;
      end else if (rbr_rd) begin
        dr_reg <= 1'b0;
      end
      if (rx_done) begin
        oe_reg <= dr_reg | (oe_reg & !lsr_rd);
        pe_reg <= (lcr_reg.parity_on & rx_perr_reg) | (pe_reg & !lsr_rd);
        fe_reg <= !rx_line | (fe_reg & !lsr_rd);
        bi_reg <= (rx_sh_reg == 8'h00 && !rx_line) | (bi_reg & !lsr_rd);
      end else if (lsr_rd) begin
        oe_reg <= 1'b0;
        pe_reg <= 1'b0;
        fe_reg <= 1'b0;
        bi_reg <= 1'b0;
      end
    end
  end
  // read mux
  splcm_pkg::splcm_lsr_t lsr;
  assign lsr = '{err: 1'b0, temt: !thr_full_reg && !tx_busy,
    thre: !thr_full_reg, bi: bi_reg, fe: fe_reg, pe: pe_reg, oe: oe_reg,
    dr: dr_reg};
  logic [7:0] rd_mux;
  always_comb begin
    case (ADDR)
      splcm_pkg::OFF_DATA: rd_mux = divisor_access_sel ? div_reg[7:0] : rbr_reg;
      splcm_pkg::OFF_IER: rd_mux = divisor_access_sel ? div_reg[15:8] : ier_reg;
      splcm_pkg::OFF_IIR: rd_mux = splcm_pkg::IIR_IDLE;
      splcm_pkg::OFF_LCR: rd_mux = lcr_reg;
      splcm_pkg::OFF_MCR: rd_mux = mcr_reg;
      splcm_pkg::OFF_LSR: rd_mux = lsr;
      splcm_pkg::OFF_MSR: rd_mux = 8'h00;
      default: rd_mux = scr_reg;
    endcase
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) rdata_reg <= 8'h00;
    else if (RD) rdata_reg <= rd_mux;
  end
  assign RDATA = rdata_reg;
endmodule : splcm_uart
`default_nettype wire

// *** verif/splcm_checker.sv ***
// checker: register map and serial line properties at the top ports
`timescale 1ns/1ns
`default_nettype none
module splcm_checker (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic SIN,
  input wire logic SERIAL_OUT_PIN
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic [7:0] lcr_reg, ier_reg, dlo_reg, dhi_reg, hic_reg;
  logic sent_reg;
  wire dl = lcr_reg[7];
  wire a0 = ADDR[0];
  ////////////////////////////////////////
  // shadow of the host-written control state
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      lcr_reg <= 8'h00;
      ier_reg <= 8'h00;
      dlo_reg <= 8'h01;
      dhi_reg <= 8'h00;
      sent_reg <= 1'b0;
    end else if (WR) begin
      if (ADDR == 3'h3) lcr_reg <= WDATA;
      if (ADDR == 3'h1 && !dl) ier_reg <= WDATA;
      if (ADDR == 3'h0 && dl) dlo_reg <= WDATA;
      if (ADDR == 3'h1 && dl) dhi_reg <= WDATA;
      if (ADDR == 3'h0 && !dl) sent_reg <= 1'b1;
    end
  end
  // cycles the line has stood high, saturating
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) hic_reg <= 8'h00;
    else if (!SERIAL_OUT_PIN) hic_reg <= 8'h00;
    else if (hic_reg != 8'hff) hic_reg <= hic_reg + 8'h01;
  end
  a_break_low: assert property (lcr_reg[6] |-> !SERIAL_OUT_PIN)
    else $error("line not held low in break");
  a_idle_high: assert property (!lcr_reg[6] && !sent_reg |-> SERIAL_OUT_PIN)
    else $error("line left idle level");
  a_start_bit: assert property (
    WR && ADDR == 3'h0 && !dl && !lcr_reg[6] && hic_reg > 8'hc8
    |-> ##[1:40] !SERIAL_OUT_PIN) else $error("no start bit");
  a_low_width: assert property (
    $fell(SERIAL_OUT_PIN) && !lcr_reg[6] |-> !SERIAL_OUT_PIN [*8])
    else $error("low bit too short");
  a_rd_hold: assert property (!$past(RD) |-> $stable(RDATA))
    else $error("read data moved");
  a_lcr_read: assert property (RD && ADDR == 3'h3 |=> RDATA == lcr_reg)
    else $error("format register readback");
  a_div_read: assert property (RD && dl && ADDR[2:1] == 2'b00
    |=> RDATA == ($past(a0) ? dhi_reg : dlo_reg)) else $error("divisor read");
  a_ier_read: assert property (RD && !dl && ADDR == 3'h1
    |=> RDATA == (ier_reg & splcm_pkg::IER_MASK)) else $error("enable read");
  c_break: cover property ($rose(lcr_reg[6]));
  c_frame: cover property (sent_reg && $fell(SERIAL_OUT_PIN));
  c_divrd: cover property (RD && dl);
endmodule : splcm_checker
`default_nettype wire

// *** verif/splcm_term.sv ***
// partner: remote terminal that samples frames and sends bytes
`timescale 1ns/1ns
`default_nettype none
module splcm_term (
  input wire logic clk,
  input wire logic line,
  input wire logic [7:0] bit_cyc,
  input wire logic [7:0] tx_byte,
  input wire logic tx_go,
  output logic sin,
  output logic got,
  output logic [11:0] frame
);
  ////////////////////////////////////////
  // take twelve mid-bit samples after each falling edge
  initial begin
    got = 1'b0;
    frame = 12'h000;
    forever begin
      @(negedge line);
      repeat (bit_cyc / 2) @(negedge clk);
      for (int k = 0; k < 12; k++) begin
        frame[k] = line;
        if (k < 11) repeat (bit_cyc) @(negedge clk);
      end
      got = 1'b1;
      @(negedge clk);
      got = 1'b0;
    end
  end
  // send one eight-bit frame, low bit first, one stop bit
  initial begin
    sin = 1'b1;
    forever begin
      @(posedge tx_go);
      for (int k = 0; k < 10; k++) begin
        sin = (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : tx_byte[k-1];
        repeat (bit_cyc) @(negedge clk);
      end
    end
  end
endmodule : splcm_term
`default_nettype wire

// *** verif/test_serial_port_line_control_map.sv ***
// testbench: register map, frame format and break of the serial port
`timescale 1ns/1ns
`default_nettype none
module test_serial_port_line_control_map;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] rdata, tx_byte = 8'h00, bit_cyc = 8'h10;
  logic sin, serial_out_pin, got, tx_go = 1'b0;
  logic [11:0] frame;
  logic [7:0] rdq[$];
  logic [11:0] txq[$];
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  always #25 core_clk = ~core_clk;
  splcm_uart dut (.CORE_CLK(core_clk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SIN(sin),
    .SERIAL_OUT_PIN(serial_out_pin));
  splcm_term term (.clk(core_clk), .line(serial_out_pin), .bit_cyc(bit_cyc),
    .tx_byte(tx_byte), .tx_go(tx_go), .sin(sin), .got(got), .frame(frame));
  ////////////////////////////////////////
  task automatic end_of_test();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [11:0] a, input logic [11:0] e,
                       input string m);
    n_compared++;
    if (a !== e) begin
      num_errors++;
      $display("unexpected at %0t: %s %h not %h", $time, m, a, e);
    end
  endtask : check
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
    rdq.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(posedge core_clk);
  endtask : rd_reg
  // expected frame, low bit first, idle ones after the stop bit
  function automatic logic [11:0] exp_frame(input logic [7:0] c,
                                            input logic [7:0] d);
    logic [11:0] f;
    logic p;
    int n;
    n = 5 + c[1:0];
    p = ^(d & (8'hff >> (8 - n)));
    f = 12'hfff;
    f[0] = 1'b0;
    for (int k = 0; k < n; k++) f[k+1] = d[k];
    if (c[3]) f[n+1] = c[5] ? ~c[4] : (p ^ ~c[4]);
    return f;
  endfunction : exp_frame
  // busy one tick before the frame's end, empty two cycles later
  task automatic send(input logic [7:0] c, input logic [7:0] d);
    int n;
    int len;
    int k;
    n = 5 + c[1:0];
    len = 16 * (1 + n + c[3]) + (!c[2] ? 16 : (n == 5) ? 24 : 32);
    wr_reg(3'h3, c);
    txq.push_back(exp_frame(c, d));
    wr_reg(3'h0, d);
    k = bit_cyc / 16;
    repeat (k * (len - 1)) @(posedge core_clk);
    rd_reg(3'h5, 8'h20);
    rd_reg(3'h5, 8'h60);
    repeat (300) @(posedge core_clk);
  endtask : send
  // compare each read and each captured frame with the oldest note
  always @(posedge core_clk) begin
    rd_d <= rd;
    if (rd_d) check({4'h0, rdata}, rdq.pop_front(), "read");
    if (got) check(frame, txq.size() ? txq.pop_front() : 12'hxxx, "frame");
  end
  // cut a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    logic [7:0] d;
    void'($urandom(79));
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd_reg(3'h3, 8'h00);
    wr_reg(3'h3, 8'h80);
    wr_reg(3'h0, 8'h5a);
    wr_reg(3'h1, 8'ha5);
    rd_reg(3'h0, 8'h5a);
    rd_reg(3'h1, 8'ha5);
    rd_reg(3'h3, 8'h80);
    wr_reg(3'h0, 8'h01);
    wr_reg(3'h1, 8'h00);
    wr_reg(3'h3, 8'h00);
    wr_reg(3'h1, 8'hff);
    rd_reg(3'h1, 8'h0f);
    for (int i = 0; i < 12; i++) begin
      d = $urandom;
      send({2'b00, i >= 8, 1'($urandom), i >= 4, 1'($urandom), i[1:0]}, d);
    end
    txq.push_back(12'h000);
    wr_reg(3'h3, 8'h43);
    repeat (250) @(posedge core_clk);
    wr_reg(3'h3, 8'h03);
    repeat (300) @(posedge core_clk);
    wr_reg(3'h3, 8'h83);
    wr_reg(3'h0, 8'h02);
    wr_reg(3'h1, 8'h00);
    wr_reg(3'h3, 8'h03);
    bit_cyc <= 8'h20;
    send(8'h03, 8'hc3);
    tx_byte <= 8'h96;
    tx_go <= 1'b1;
    @(posedge core_clk);
    tx_go <= 1'b0;
    repeat (400) @(posedge core_clk);
    rd_reg(3'h0, 8'h96);
    repeat (2) @(posedge core_clk);
    check(12'(txq.size() + rdq.size()), 12'h000, "notes left");
    end_of_test();
  end
endmodule : test_serial_port_line_control_map
bind splcm_uart splcm_checker chk (.CORE_CLK(CORE_CLK), .RST(RST),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SIN(SIN),
  .SERIAL_OUT_PIN(SERIAL_OUT_PIN));
`default_nettype wire
